/* design/rw_buffer_fifo_latch.sv */
// Top of the 18-bit read/write buffer: write FIFO, readback latch, port drivers
`timescale 1ns/1ps
module rw_buffer_fifo_latch
  import rw_buffer_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fifo_reset_n,
  input wire logic fifo_write_enable_n,
  input wire logic fifo_read_enable_n,
  input wire logic memside_output_enable_n,
  input wire logic hostside_output_enable_n,
  input wire logic readback_latch_enable,
  input wire logic [WIDTH-1:0] host_side_port_i,
  output logic [WIDTH-1:0] host_side_port_o,
  output logic host_side_port_oe,
  input wire logic [WIDTH-1:0] memory_side_port_i,
  output logic [WIDTH-1:0] memory_side_port_o,
  output logic memory_side_port_oe,
  output logic fifo_full_n
);

  ////////////////////////////////////////////////////////////////////////
  // Types and helpers

  // Kind of FIFO access granted at one edge
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_PUSH,
    OP_POP,
    OP_BOTH
  } fifo_op_t;

  // Only the two boundaries change the arbitration
  typedef enum logic [1:0] {
    OCC_EMPTY,
    OCC_PARTIAL,
    OCC_FULL
  } occ_t;

  // Wraps at the last entry, so the depth need not be a power of two
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? PTR_RESET : p + PTR_W'(1);
  endfunction

  // Entry picked by a pointer; shared by write select and read mux
  function automatic logic entry_hit(input logic [PTR_W-1:0] p, input int idx);
    entry_hit = (p == PTR_W'(idx));
  endfunction

  function automatic occ_t occ_class(input logic [CNT_W-1:0] c);
    if (c == CNT_RESET) begin
      occ_class = OCC_EMPTY;
    end else if (c == CNT_W'(DEPTH)) begin
      occ_class = OCC_FULL;
    end else begin
      occ_class = OCC_PARTIAL;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] head_pick [DEPTH];
  logic [DEPTH-1:0] entry_we;
  logic [WIDTH-1:0] head_word;
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] count_ff;
  logic [WIDTH-1:0] fifo_out_ff;
  logic full_n_ff;
  logic [PTR_W-1:0] nxt_wr_ptr;
  logic [PTR_W-1:0] nxt_rd_ptr;
  logic [CNT_W-1:0] nxt_count;
  logic [WIDTH-1:0] nxt_fifo_out;
  logic nxt_full_n;
  fifo_op_t op_sel;
  occ_t occ_now;

  ////////////////////////////////////////////////////////////////////////
  // Decode of requests against occupancy

  wire wr_req = ~fifo_write_enable_n;
  wire rd_req = ~fifo_read_enable_n;
  wire sync_clear = ~fifo_reset_n;
  wire fifo_empty = (occ_now == OCC_EMPTY);
  wire fifo_full = (occ_now == OCC_FULL);
  // Empty blocks reads and full blocks writes; a clear overrides both
  wire do_wr = wr_req & ~fifo_full & ~sync_clear;
  wire do_rd = rd_req & ~fifo_empty & ~sync_clear;

  assign occ_now = occ_class(count_ff);

  // Encoding of granted accesses
  always_comb begin
    if (do_wr && do_rd) begin
      op_sel = OP_BOTH;
    end else if (do_wr) begin
      op_sel = OP_PUSH;
    end else if (do_rd) begin
      op_sel = OP_POP;
    end else begin
      op_sel = OP_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage entries and read mux

  // Storage has no reset; pointers decide which entries are valid
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    assign entry_we[g] = do_wr & entry_hit(wr_ptr_ff, g);
    always_ff @(posedge clk_sys) begin
      if (entry_we[g]) begin
        mem_ff[g] <= host_side_port_i;
      end
    end
    assign head_pick[g] = entry_hit(rd_ptr_ff, g) ? mem_ff[g] : '0;
  end

  // Unselected entries give zeros so one OR tree forms the mux
  always_comb begin
    head_word = '0;
    for (int i = 0; i < DEPTH; i++) begin
      head_word = head_word | head_pick[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  // Output register shows the head word as it is read
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    nxt_fifo_out = fifo_out_ff;
    case (op_sel)
      OP_PUSH: begin
        nxt_wr_ptr = ptr_inc(wr_ptr_ff);
        nxt_count = count_ff + CNT_W'(1);
      end
      OP_POP: begin
        nxt_rd_ptr = ptr_inc(rd_ptr_ff);
        nxt_count = count_ff - CNT_W'(1);
        nxt_fifo_out = head_word;
      end
      OP_BOTH: begin
        nxt_wr_ptr = ptr_inc(wr_ptr_ff);
        nxt_rd_ptr = ptr_inc(rd_ptr_ff);
        nxt_fifo_out = head_word;
      end
      default: begin
        nxt_count = count_ff;
      end
    endcase
    if (sync_clear) begin
      nxt_wr_ptr = PTR_RESET;
      nxt_rd_ptr = PTR_RESET;
      nxt_count = CNT_RESET;
      nxt_fifo_out = FIFO_OUT_RESET;
    end
    // Flag follows the new count, so it moves on the same edge
    nxt_full_n = sync_clear ? FULL_N_RESET : (nxt_count != CNT_W'(DEPTH));
  end

  ////////////////////////////////////////////////////////////////////////
  // Clocked FIFO state, one shared clock for both sides

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= PTR_RESET;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_ptr_ff <= PTR_RESET;
    end else begin
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_ff <= CNT_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fifo_out_ff <= FIFO_OUT_RESET;
    end else begin
      fifo_out_ff <= nxt_fifo_out;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      full_n_ff <= FULL_N_RESET;
    end else begin
      full_n_ff <= nxt_full_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path latch, separate from the FIFO

  logic [WIDTH-1:0] latch_q;

  readback_latch #(
    .WIDTH(WIDTH)
  ) u_latch (
    .d(memory_side_port_i),
    .latch_enable(readback_latch_enable),
    .q(latch_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Port drivers

  assign fifo_full_n = full_n_ff;
  assign memory_side_port_o = fifo_out_ff;
  assign memory_side_port_oe = ~memside_output_enable_n;
  assign host_side_port_o = latch_q;
  assign host_side_port_oe = ~hostside_output_enable_n;

endmodule // rw_buffer_fifo_latch

/* design/rw_buffer_pkg.sv */
// Package with widths, depths and reset values of the read/write buffer
package rw_buffer_pkg;
  localparam int DATA_W = 18;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;
  localparam logic [DATA_W-1:0] FIFO_OUT_RESET = 18'h3ffff;
  localparam logic [PTR_W-1:0] PTR_RESET = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
  localparam logic FULL_N_RESET = 1'b1;
endpackage

/* design/readback_latch.sv */
// Transparent readback latch from memory side to host side
`timescale 1ns/1ps
module readback_latch
  import rw_buffer_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic [WIDTH-1:0] d,
  input wire logic latch_enable,
  output logic [WIDTH-1:0] q
);
  // Level latch on purpose: pass while enable high, hold after it falls
  always_latch begin
    if (latch_enable) begin
      q = d;
    end
  end
endmodule // readback_latch

/* test/mem_side_model.sv */
// Memory side partner
`timescale 1ns/1ps
module mem_side_model import rw_buffer_pkg::*; (
  input wire logic clk_sys, dev_oe, mem_drive,
  input wire logic [DATA_W-1:0] dev_word, mem_word,
  output logic [DATA_W-1:0] bus);
  logic noise_ff = 1'b0;
  // Released bus toggles, stale data never matches
  always @(posedge clk_sys) noise_ff <= ~noise_ff;
  assign bus = dev_oe ? dev_word : mem_drive ? mem_word : {DATA_W{noise_ff}} ^ 18'h15555;
endmodule // mem_side_model

/* test/rw_buffer_fifo_latch_assertions.sv */
// Port checker
`timescale 1ns/1ps
module rw_buffer_chk import rw_buffer_pkg::*; (
  input wire logic clk_sys, rst, fifo_reset_n, fifo_write_enable_n, fifo_read_enable_n,
  input wire logic memside_output_enable_n, readback_latch_enable, fifo_full_n,
  input wire logic [DATA_W-1:0] memory_side_port_i, host_side_port_o, memory_side_port_o,
  input wire logic memory_side_port_oe);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire idle_r = fifo_read_enable_n && fifo_reset_n;
  sequence s_four_wr;
    (!fifo_write_enable_n && idle_r)[*4];
  endsequence
  a_fill_sets_full: assert property (!fifo_reset_n ##1 s_four_wr |=> !fifo_full_n)
    else $error("full");
  a_reset_all_ones: assert property (!fifo_reset_n |=>
    memory_side_port_o == 18'h3ffff && fifo_full_n) else $error("reset");
  a_full_wr_drop: assert property (!fifo_full_n && idle_r |=> !fifo_full_n)
    else $error("drop");
  a_full_read_ok: assert property (!fifo_full_n && !fifo_read_enable_n && fifo_reset_n
    |=> fifo_full_n) else $error("read");
  a_no_read_hold: assert property (idle_r |=> $stable(memory_side_port_o))
    else $error("hold");
  a_latch_flows: assert property (readback_latch_enable |->
    host_side_port_o == memory_side_port_i) else $error("flow");
  a_latch_holds: assert property (!readback_latch_enable [*2] |->
    $stable(host_side_port_o)) else $error("latch");
  a_memoe_map: assert property (memory_side_port_oe != memside_output_enable_n)
    else $error("oe");
endmodule // rw_buffer_chk
bind rw_buffer_fifo_latch rw_buffer_chk chk_i (.clk_sys, .rst, .fifo_reset_n,
  .fifo_write_enable_n, .fifo_read_enable_n, .memside_output_enable_n, .readback_latch_enable,
  .fifo_full_n, .memory_side_port_i, .host_side_port_o, .memory_side_port_o,
  .memory_side_port_oe);

/* test/rw_buffer_fifo_latch_tb.sv */
// Self-checking bench for the read/write buffer
`timescale 1ns/1ps
module rw_buffer_fifo_latch_tb import rw_buffer_pkg::*; ;
  logic clk_sys = 0, rst = 1, rsn = 1, wen = 1, ren = 1, moe = 1, hoe = 0, le = 1, md = 0;
  logic [DATA_W-1:0] hin = '0, mw = '0, ho, mo, bus;
  logic hoe_o, moe_o, full_n;
  int fail_count = 0, total_checks = 0;
  initial forever #20 clk_sys = ~clk_sys;
  rw_buffer_fifo_latch DUT (.clk_sys, .rst, .fifo_reset_n(rsn), .fifo_write_enable_n(wen),
    .fifo_read_enable_n(ren), .memside_output_enable_n(moe), .hostside_output_enable_n(hoe),
    .readback_latch_enable(le), .host_side_port_i(hin), .host_side_port_o(ho),
    .host_side_port_oe(hoe_o), .memory_side_port_i(bus), .memory_side_port_o(mo),
    .memory_side_port_oe(moe_o), .fifo_full_n(full_n));
  mem_side_model mem (.clk_sys, .dev_oe(moe_o), .mem_drive(md), .dev_word(mo),
    .mem_word(mw), .bus);
  task chk(input logic [DATA_W-1:0] g, e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task op(input logic w, r, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    wen <= ~w;
    ren <= ~r;
    hin <= d;
  endtask
  task look; op(0, 0, 0); @(negedge clk_sys); endtask
  task t_fill;
    @(posedge clk_sys) rsn <= 0;
    @(posedge clk_sys) rsn <= 1;
    @(negedge clk_sys) chk(mo, 18'h3ffff);
    chk(full_n, 1);
    for (int i = 0; i < 3; i++) op(1, 0, 18'h2a5a0 + i);
    look;
    chk(full_n, 1);
    op(1, 0, 18'h2a5a3);
    op(1, 0, 18'h00bad);
    look;
    chk(full_n, 0);
    op(1, 1, 18'h0f00d);
    look;
    chk(mo, 18'h2a5a0);
    for (int i = 1; i < 5; i++) begin
      op(0, 1, 0);
      look;
      chk(mo, 18'h2a5a0 + (i < 4 ? i : 3));
    end
    $display("fill done");
  endtask
  task t_both;
    op(1, 1, 18'h1c3c3);
    look;
    chk(mo, 18'h2a5a3);
    op(1, 1, 18'h0f0f0);
    look;
    chk(mo, 18'h1c3c3);
    $display("both done");
  endtask
  task t_latch;
    @(posedge clk_sys) mw <= 18'h12345;
    md <= 1;
    @(negedge clk_sys) chk(ho, 18'h12345);
    chk(hoe_o, 1);
    @(posedge clk_sys) le <= 0;
    @(posedge clk_sys) {md, moe, hoe} <= 3'h1;
    mw <= 18'h00abc;
    @(negedge clk_sys) chk(ho, 18'h12345);
    chk(bus, 18'h1c3c3);
    chk(hoe_o, 0);
    $display("latch done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    t_fill;
    t_both;
    t_latch;
    end_of_test;
  end
  initial begin
    #200us;
    fail_count++;
    end_of_test;
  end
endmodule // rw_buffer_fifo_latch_tb
